/* common/sync_card_params.svh */
// Offsets, field positions and reset values of the synchronous card line block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef SYNC_CARD_PARAMS_SVH
`define SYNC_CARD_PARAMS_SVH
`define CARD_CTL_OFS     8'h80
`define LINE_RST_OFS     8'h90
`define LINE_CLK_OFS     8'h94
`define LINE_FCB_OFS     8'h98
`define LINE_SPU_OFS     8'h9c
`define LINE_IO_OFS      8'ha0
`define BIT_IN_EN        13
`define BIT_OUT_EN       12
`define BIT_FAST_OD      11
`define BIT_OPEN_DRAIN   10
`define BIT_PULL_UP      9
`define BIT_WEAK_LOW     8
`define BIT_PIN_SAMPLE   1
`define BIT_DRIVE_VAL    0
`define BIT_SYNC_SEL     0
`define BIT_PORT_EN      7
`define LINE_RESET_VAL   14'h0000
`define CTL_RESET_VAL    8'h00
`define LINE_WR_MASK     32'h00003f01
`define CTL_WR_MASK      32'h000000d7
`define FAST_HIGH_NS     100
`define CLK_PERIOD_NS    100
`define FAST_HIGH_CYC    (((`FAST_HIGH_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`endif

/* common/sync_card_pkg.sv */
// Types shared by the synchronous card line block.
// Assumes the params header for numeric constants.
package sync_card_pkg;
  typedef enum logic [2:0]
  {
    LINE_RESET = 3'h0,
    LINE_CLOCK = 3'h1,
    LINE_FCB   = 3'h2,
    LINE_SPU   = 3'h3,
    LINE_IO    = 3'h4
  } line_idx_t;
  typedef logic [13:0] line_cfg_t;
endpackage

/* hw/card_line_pad.sv */
// One card line pad driver: drive style, fast open-drain pulse and pin sampler.
// Assumes one clock; the pin input arrives asynchronously from the card.
`timescale 1ns/10ps
`default_nettype none
`include "sync_card_params.svh"
module card_line_pad
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [13:0] cfg_i,
  input  wire logic        port_en_i,
  input  wire logic        pin_i,
  output logic             pin_o,
  output logic             pin_oe_n_o,
  output logic             pull_up_o,
  output logic             pull_dn_o,
  output logic             sample_o
);
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic       sample_r;
  logic       sample_nxt;
  logic       val_d_r;
  logic       val_d_nxt;
  logic       drv_r;
  logic       drv_nxt;
  logic       oe_n_r;
  logic       oe_n_nxt;
  logic       pu_r;
  logic       pu_nxt;
  logic       pd_r;
  logic       pd_nxt;

  // Next-value logic; the sample only moves when the last two stages agree.
  always_comb
  begin
    sync_nxt   = {sync_r[1:0], pin_i};
    sample_nxt = sample_r;
    if (sync_r[2] == sync_r[1])
    begin
      sample_nxt = sync_r[2];
    end
    val_d_nxt = cfg_i[`BIT_DRIVE_VAL];
    drv_nxt   = cfg_i[`BIT_DRIVE_VAL];
    oe_n_nxt  = 1'b1;
    pu_nxt    = port_en_i & cfg_i[`BIT_PULL_UP];
    pd_nxt    = port_en_i & cfg_i[`BIT_WEAK_LOW];
    if (port_en_i && cfg_i[`BIT_OUT_EN])
    begin
      if (cfg_i[`BIT_FAST_OD])
      begin
        oe_n_nxt = cfg_i[`BIT_DRIVE_VAL] & val_d_r;
      end
      else if (cfg_i[`BIT_OPEN_DRAIN])
      begin
        oe_n_nxt = cfg_i[`BIT_DRIVE_VAL];
      end
      else
      begin
        oe_n_nxt = 1'b0;
      end
    end
  end

  // Register stage; all outputs but sample_o come straight from these flops.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync_r   <= 3'h0;
      sample_r <= 1'b0;
      val_d_r  <= 1'b0;
      drv_r    <= 1'b0;
      oe_n_r   <= 1'b1;
      pu_r     <= 1'b0;
      pd_r     <= 1'b0;
    end
    else
    begin
      sync_r   <= sync_nxt;
      sample_r <= sample_nxt;
      val_d_r  <= val_d_nxt;
      drv_r    <= drv_nxt;
      oe_n_r   <= oe_n_nxt;
      pu_r     <= pu_nxt;
      pd_r     <= pd_nxt;
    end
  end

  // input path gate; a disabled input reads zero.
  assign sample_o   = sample_r & cfg_i[`BIT_IN_EN];
  assign pin_o      = drv_r;
  assign pin_oe_n_o = oe_n_r;
  assign pull_up_o  = pu_r;
  assign pull_dn_o  = pd_r;

  fast_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!oe_n_r && drv_r && $past(cfg_i[`BIT_FAST_OD]) && $past(cfg_i[`BIT_OUT_EN])
     && $past(port_en_i) && $past(val_d_r)) |-> 1'b0)
    else $error("Fast open-drain drove high more than one cycle.");
  od_no_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(cfg_i[`BIT_OPEN_DRAIN]) && !$past(cfg_i[`BIT_FAST_OD]) && !oe_n_r) |-> !drv_r)
    else $error("Open drain drove a high level.");
  oe_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(cfg_i[`BIT_OUT_EN]) |-> oe_n_r)
    else $error("Pin driven while output disabled.");
endmodule
`default_nettype wire

/* hw/sync_card_line_control.sv */
// Synchronous card line control: five line registers and a card control register on Wishbone.
// Assumes classic Wishbone with 32-bit data, byte selects, one clock and synchronous reset.
`timescale 1ns/10ps
`default_nettype none
`include "sync_card_params.svh"
module sync_card_line_control
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [4:0]  line_pin_i,
  output logic      [4:0]  line_pin_o,
  output logic      [4:0]  line_pin_oe_n_o,
  output logic      [4:0]  pull_up_o,
  output logic      [4:0]  weak_low_bias_o
);
  import sync_card_pkg::*;

  sync_card_pkg::line_cfg_t cfg_r [5];
  sync_card_pkg::line_cfg_t cfg_nxt [5];
  logic [7:0]  ctl_r;
  logic [7:0]  ctl_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic        ack_r;
  logic        ack_nxt;
  logic [4:0]  sample;
  logic [4:0]  port_en;
  logic [31:0] bmask;
  logic        req;
  logic        hit_line;
  logic        hit_ctl;
  logic [2:0]  line_sel;

  // A request is new only while ack is low, so each access answers once.
  assign req = cyc_i & stb_i & ~ack_r;
  assign bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  // Address decode; unmapped addresses ack with zero data and drop writes.
  always_comb
  begin
    hit_line = 1'b0;
    hit_ctl  = 1'b0;
    line_sel = 3'h0;
    if (adr_i[7:2] == 6'(`LINE_RST_OFS >> 2))
    begin
      hit_line = 1'b1;
      line_sel = LINE_RESET;
    end
    else if (adr_i[7:2] == 6'(`LINE_CLK_OFS >> 2))
    begin
      hit_line = 1'b1;
      line_sel = LINE_CLOCK;
    end
    else if (adr_i[7:2] == 6'(`LINE_FCB_OFS >> 2))
    begin
      hit_line = 1'b1;
      line_sel = LINE_FCB;
    end
    else if (adr_i[7:2] == 6'(`LINE_SPU_OFS >> 2))
    begin
      hit_line = 1'b1;
      line_sel = LINE_SPU;
    end
    else if (adr_i[7:2] == 6'(`LINE_IO_OFS >> 2))
    begin
      hit_line = 1'b1;
      line_sel = LINE_IO;
    end
    else if (adr_i[7:2] == 6'(`CARD_CTL_OFS >> 2))
    begin
      hit_ctl = 1'b1;
    end
  end

  // Register write and read next values.
  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      cfg_nxt[i] = cfg_r[i];
    end
    ctl_nxt = ctl_r;
    dat_nxt = dat_r;
    ack_nxt = req;
    if (req && we_i && hit_line)
    begin
      cfg_nxt[line_sel] = 14'((({18'h0, cfg_r[line_sel]} & ~(bmask & `LINE_WR_MASK))
                        | (dat_i & bmask & `LINE_WR_MASK)));
    end
    if (req && we_i && hit_ctl && sel_i[0])
    begin
      ctl_nxt = 8'(dat_i & `CTL_WR_MASK);
    end
    if (req && !we_i)
    begin
      dat_nxt = 32'h0;
      if (hit_line)
      begin
        dat_nxt = {18'h0, cfg_r[line_sel][13:2], sample[line_sel], cfg_r[line_sel][0]};
      end
      else if (hit_ctl)
      begin
        dat_nxt = {24'h0, ctl_r};
      end
    end
  end

  // Register stage for control state and bus answer.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 5; i++)
      begin
        cfg_r[i] <= `LINE_RESET_VAL;
      end
      ctl_r <= `CTL_RESET_VAL;
      dat_r <= 32'h0;
      ack_r <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 5; i++)
      begin
        cfg_r[i] <= cfg_nxt[i];
      end
      ctl_r <= ctl_nxt;
      dat_r <= dat_nxt;
      ack_r <= ack_nxt;
    end
  end

  assign dat_o = dat_r;
  assign ack_o = ack_r;

  assign port_en = {5{ctl_r[`BIT_PORT_EN] & ctl_r[`BIT_SYNC_SEL]}};

  generate
    for (genvar g = 0; g < 5; g++)
    begin : g_line
      card_line_pad u_pad
      (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .cfg_i      (cfg_r[g]),
        .port_en_i  (port_en[g]),
        .pin_i      (line_pin_i[g]),
        .pin_o      (line_pin_o[g]),
        .pin_oe_n_o (line_pin_oe_n_o[g]),
        .pull_up_o  (pull_up_o[g]),
        .pull_dn_o  (weak_low_bias_o[g]),
        .sample_o   (sample[g])
      );
    end
  endgenerate

  port_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(ctl_r[`BIT_PORT_EN]) |-> (line_pin_oe_n_o == 5'h1f))
    else $error("Card pin driven while port disabled.");
  push_pull_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(port_en[0]) && $past(cfg_r[0][12:10]) == 3'b100) |-> !line_pin_oe_n_o[0])
    else $error("Enabled push-pull line not driven.");
  pull_up_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(port_en[1]) |-> (pull_up_o[1] == $past(cfg_r[1][9])))
    else $error("Pull-up does not follow its bit.");
  pull_dn_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(port_en[0]) |-> (weak_low_bias_o[0] == $past(cfg_r[0][8])))
    else $error("Pull-down does not follow its bit.");
  byte_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && we_i && hit_line && sel_i == 4'h1) |=> (cfg_r[$past(line_sel)][13:8]
      == $past(cfg_r[line_sel][13:8])))
    else $error("Byte write disturbed another byte.");
  rst_val_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && we_i && adr_i == `LINE_RST_OFS && sel_i[0]) |=> (cfg_r[0][0] == $past(dat_i[0])))
    else $error("Reset line drive value not stored.");
  clk_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && adr_i == `LINE_CLK_OFS) |=> (ack_o && dat_o[31:14] == 18'h0
      && dat_o[7:2] == 6'h0 && dat_o[0] == $past(cfg_r[1][0])))
    else $error("Clock line read back wrong.");
  // Bus answer timing.
  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("Ack held more than one cycle.");

  // Every taken request is answered on the very next edge.
  ack_next_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> ack_o)
    else $error("Request not answered in one cycle.");

  // No answer without a cycle on the bus.
  ack_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !cyc_i |=> !ack_o)
    else $error("Ack without a bus cycle.");

  // Unmapped reads return zero.
  bad_adr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && !hit_line && !hit_ctl) |=> (dat_o == 32'h0))
    else $error("Unmapped read returned data.");

  rsvd_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && hit_line) |=> (dat_o[31:14] == 18'h0 && dat_o[7:2] == 6'h0))
    else $error("Reserved line bits read nonzero.");

  high_lane_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && we_i && hit_line && sel_i[1:0] == 2'h0)
    |=> (cfg_r[$past(line_sel)] == $past(cfg_r[line_sel])))
    else $error("Upper byte write changed a line register.");

  in_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && hit_line && !cfg_r[line_sel][`BIT_IN_EN]) |=> !dat_o[1])
    else $error("Disabled input read back a one.");

  ctl_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && we_i && hit_ctl && sel_i[0])
    |=> (ctl_r == ($past(dat_i[7:0]) & 8'(`CTL_WR_MASK))))
    else $error("Card control write not stored.");

  sync_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(ctl_r[`BIT_SYNC_SEL]) |-> (line_pin_oe_n_o == 5'h1f))
    else $error("Card pin driven outside synchronous mode.");

  od_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(port_en[1]) && $past(cfg_r[1][12:10]) == 3'b101)
    |-> (line_pin_oe_n_o[1] == $past(cfg_r[1][0]) && !line_pin_o[1]))
    else $error("Open drain line level wrong.");

  // fast drive steps; the value rise and the hold are separate steps.
  sequence fast_rise_s;
    port_en[0] && cfg_r[0][12:11] == 2'b11 && cfg_r[0][0] && !$past(cfg_r[0][0]);
  endsequence
  sequence fast_hold_s;
    port_en[0] && cfg_r[0][12:11] == 2'b11 && cfg_r[0][0];
  endsequence

  fast_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fast_rise_s |=> (!line_pin_oe_n_o[0] && line_pin_o[0]))
    else $error("Fast drive missed its high cycle.");

  fast_float_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fast_rise_s ##1 fast_hold_s |=> line_pin_oe_n_o[0])
    else $error("Fast drive did not float after its pulse.");

  fast_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(port_en[0]) && $past(cfg_r[0][12:11]) == 2'b11 && !$past(cfg_r[0][0]))
    |-> (!line_pin_oe_n_o[0] && !line_pin_o[0]))
    else $error("Fast drive did not pull low.");

  // the same drive rules hold on every line.
  generate
    for (genvar k = 0; k < 5; k++)
    begin : g_chk
      line_float_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(cfg_r[k][`BIT_OUT_EN]) |-> line_pin_oe_n_o[k])
        else $error("Line driven while its output is disabled.");

      line_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ($past(port_en[k]) && $past(cfg_r[k][12:10]) == 3'b100)
        |-> (!line_pin_oe_n_o[k] && line_pin_o[k] == $past(cfg_r[k][0])))
        else $error("Push-pull line level wrong.");

      pull_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(port_en[k]) |-> (!pull_up_o[k] && !weak_low_bias_o[k]))
        else $error("Pull enabled while port disabled.");
    end
  endgenerate
endmodule
`default_nettype wire

/* testbench/card_model.sv */
// Card side of the five card lines: resolves each line level from the pad drive,
// the pulls and the card's own drive. Assumes the bench commands the card drive.
`timescale 1ns/10ps
`default_nettype none
module card_model
(
  input  wire logic       clk_i,
  input  wire logic [4:0] drv_i,
  input  wire logic [4:0] oe_n_i,
  input  wire logic [4:0] pu_i,
  input  wire logic [4:0] pd_i,
  input  wire logic [4:0] card_en_i,
  input  wire logic [4:0] card_val_i,
  output logic      [4:0] level_o
);
  // Starts low so that a floating line has a known level from the first cycle.
  logic [4:0] last_r = 5'h00;
  // A line nobody drives or biases shows the inverse of its last level.
  // The simulator would otherwise settle it to a level of its own choosing.
  // pull resolution
  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      if (!oe_n_i[i])
        level_o[i] = drv_i[i];
      else if (card_en_i[i])
        level_o[i] = card_val_i[i];
      else if (pu_i[i])
        level_o[i] = 1'b1;
      else if (pd_i[i])
        level_o[i] = 1'b0;
      else
        level_o[i] = ~last_r[i];
    end
  end
  // Remember the last level of every line.
  always_ff @(posedge clk_i)
    last_r <= level_o;
endmodule
`default_nettype wire

/* testbench/test_sync_card_line_control.sv */
// Bench for the card line block: Wishbone register tasks and pin checks.
// Assumes the card model on the lines and a 100 ns clock.
`timescale 1ns/10ps
`default_nettype none
module test_sync_card_line_control;
  logic        clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, ack_o;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, dat_o, rd;
  logic [4:0]  lvl, pin_o, oe_n, pu, pd, card_en = 5'h00, card_val = 5'h00;
  int          errors = 0, n_tests = 0, cycles = 0, cnt;
  sync_card_line_control u_sync_card_line_control (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
    .dat_i(wdat), .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(dat_o),
    .ack_o(ack_o), .line_pin_i(lvl), .line_pin_o(pin_o), .line_pin_oe_n_o(oe_n),
    .pull_up_o(pu), .weak_low_bias_o(pd));
  card_model u_card_model (.clk_i(clk_i), .drv_i(pin_o), .oe_n_i(oe_n), .pu_i(pu),
    .pd_i(pd), .card_en_i(card_en), .card_val_i(card_val), .level_o(lvl));
  // Clock and hang guard.
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle; the request holds until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1)
      @(posedge clk_i);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, 4'hf, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 4'hf, 32'h0);
    chk(rd, e);
  endtask
  // Pad outputs are registered, so let a few edges pass before looking.
  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic t_reset_lanes();
    rd_chk(8'h90, 32'h0);
    rd_chk(8'h94, 32'h0);
    wr(8'ha4, 32'hffffffff);
    rd_chk(8'ha4, 32'h0);
    wb(1'b1, 8'h94, 4'h2, 32'hffffffff);
    rd_chk(8'h94, 32'h00003f00);
    wb(1'b1, 8'h94, 4'h1, 32'hffffffff);
    rd_chk(8'h94, 32'h00003f01);
    wb(1'b1, 8'h94, 4'h2, 32'h0);
    rd_chk(8'h94, 32'h00000001);
  endtask
  task automatic t_lines();
    wr(8'h80, 32'h81);
    rd_chk(8'h80, 32'h81);
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h90 + 8'(4 * i), 32'h1001);
      settle();
      chk(oe_n[i], 1'b0);
      chk(pin_o[i], 1'b1);
      wr(8'h90 + 8'(4 * i), 32'h0001);
      settle();
      chk(oe_n[i], 1'b1);
      card_en[i] <= 1'b1;
      card_val[i] <= 1'b1;
      wr(8'h90 + 8'(4 * i), 32'h2000);
      settle();
      rd_chk(8'h90 + 8'(4 * i), 32'h2002);
      wr(8'h90 + 8'(4 * i), 32'h0);
      settle();
      rd_chk(8'h90 + 8'(4 * i), 32'h0);
      card_en[i] <= 1'b0;
    end
  endtask
  task automatic t_styles();
    wr(8'h90, 32'h1401);
    settle();
    chk(oe_n[0], 1'b1);
    wr(8'h90, 32'h1400);
    settle();
    chk({oe_n[0], pin_o[0]}, 2'b00);
    wr(8'h90, 32'h1800);
    settle();
    wr(8'h90, 32'h1801);
    #1;
    cnt = 0;
    repeat (6)
    begin
      if (oe_n[0] === 1'b0 && pin_o[0] === 1'b1)
        cnt++;
      @(posedge clk_i);
      #1;
    end
    chk(cnt, 1);
    chk(oe_n[0], 1'b1);
    wr(8'h94, 32'h0300);
    settle();
    chk(pu[1], 1'b1);
    chk(pd[1], 1'b1);
    wr(8'h94, 32'h0200);
    settle();
    chk(pd[1], 1'b0);
  endtask
  task automatic t_port();
    wr(8'h80, 32'h80);
    wr(8'h90, 32'h1001);
    settle();
    chk(oe_n[0], 1'b1);
    wr(8'h80, 32'h01);
    settle();
    chk(oe_n[0], 1'b1);
    wr(8'h80, 32'h81);
    settle();
    chk(oe_n[0], 1'b0);
  endtask
  // Main sequence.
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_lanes();
    t_lines();
    t_styles();
    t_port();
    end_sim();
  end
endmodule
`default_nettype wire
